//--- logic/fsw_cfg.svh
// Constants for the flash status register and write latch block.
`ifndef FSW_CFG_SVH
`define FSW_CFG_SVH
// Contract
// [RL1] Repeat register contents until chip select rises.
// [RL2] Bit 0 is read-only busy flag.
// [RL3] Bit 1 is volatile write latch flag.
// [RL4] Bits 2 to 5 are block protection.
// [RL5] Bit 6 is quad enable.
// [RL6] Bit 7 is status write disable.
// [RL7] Only enable and disable change write latch; code also clears it when an operation completes and on reset.
// [RL8] Status write updates bits 2 to 7.
// [RL9] Busy set during program, erase, register writes.
// [RL10] While busy, ignore all but reads, resets; code also accepts suspend during program or erase.
// [RL11] Suspend accepted during program or erase.
// [RL12] Busy clears when operation ends, any outcome.
// [RL13] Write latch low refuses guarded instructions.
// [RL14] Write enable instruction sets write latch.
// [RL15] Write disable instruction clears write latch.
// [RL16] Write latch clears after finished operations.
// [RL17] Host enables writes before page program.
// [RL18] Host enables writes before every erase.
// [RL19] Host enables writes before register writes.
// [RL20] Host enables writes before info row writes.
// [RL21] Host enables writes before protection writes.
// [RL22] Volatile parameter and bank writes need nothing; code exempts only 8'hc0, 8'h17, others need the latch.
// [RL23] Locked status ignores status writes.
// [RL24] Quad enable turns protect, hold into data.
// [RL25] Chip erase needs all protection bits zero.
`define FSW_SR_RST 8'h00
`define FSW_B_BUSY 0
`define FSW_B_WEL 1
`define FSW_B_BP 2
`define FSW_B_QE 6
`define FSW_B_STATUS_WRITE_DISABLE 7
`define FSW_PIN_IDLE 5'h1a
`define FSW_OP_LAST 5'h07
`define FSW_DAT_LAST 5'h0f
`define FSW_CNT_SAT 5'h10
`define FSW_OUT_LAST 3'h7
`define FSW_C_WR_EN 8'h06
`define FSW_C_WR_DIS 8'h04
`define FSW_C_RD_SR 8'h05
`define FSW_C_RD_EXT 8'h81
`define FSW_C_WR_SR 8'h01
`define FSW_C_SUSP 8'h75
`define FSW_C_RESUME 8'h7a
`define FSW_C_RST_EN 8'h66
`define FSW_C_RST 8'h99
`define FSW_C_CHIP_A 8'hc7
`define FSW_C_CHIP_B 8'h60
`define FSW_C_PROG_A 8'h02
`define FSW_C_PROG_B 8'h12
`define FSW_C_PROG_C 8'h32
`define FSW_C_PROG_D 8'h38
`define FSW_C_PROG_E 8'h34
`define FSW_C_PROG_F 8'h3e
`define FSW_C_ERS_A 8'hd7
`define FSW_C_ERS_B 8'h20
`define FSW_C_ERS_C 8'h21
`define FSW_C_ERS_D 8'h52
`define FSW_C_ERS_E 8'h5c
`define FSW_C_ERS_F 8'hd8
`define FSW_C_ERS_G 8'hdc
`define FSW_C_FUNC 8'h42
`define FSW_C_RP_NV 8'h65
`define FSW_C_XRP_NV 8'h85
`define FSW_C_BANK_NV 8'h18
`define FSW_C_IROW_E 8'h64
`define FSW_C_IROW_P 8'h62
`define FSW_C_PLK_A 8'hfd
`define FSW_C_PLK_B 8'he3
`define FSW_C_PLK_E 8'he4
`define FSW_C_PMODE 8'h2f
`define FSW_C_PLKBIT 8'ha6
`define FSW_C_FREEZE 8'h91
`define FSW_C_GANG_L 8'h7e
`define FSW_C_GANG_U 8'h98
`define FSW_C_PWD 8'he8
`define FSW_C_LRN_NV 8'h43
`define FSW_C_ECC 8'hb5
`define FSW_C_RP_V 8'h63
`define FSW_C_XRP_V 8'h83
`define FSW_C_BANK_V 8'hc5
`define FSW_C_DLK_A 8'hfb
`define FSW_C_DLK_B 8'he1
`define FSW_C_LRN_V 8'h4a
`define FSW_C_RP_V2 8'hc0
`define FSW_C_BANK_V2 8'h17
`endif

//--- logic/fsw_pkg.sv
// Types shared by the flash status register and write latch block.
`default_nettype none
package fsw_pkg;
   // Instruction classes seen by the write latch gate.
   typedef enum logic [2:0] {fsw_cls_none, fsw_cls_pe, fsw_cls_nv, fsw_cls_vol,
      fsw_cls_free} fsw_cls_e;
   // Write cycle states.
   typedef enum logic [1:0] {fsw_idle, fsw_busy, fsw_susp} fsw_state_e;
endpackage
`default_nettype wire

//--- logic/fsw_pin_sync.sv
// Two-stage pin synchroniser with edge detection per bit.
`timescale 1ns/1ns
`default_nettype none
module fsw_pin_sync #(
   parameter int W = 5,
   parameter logic [W-1:0] IDLE = '0
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   // ****************************************
   // Per-bit synchroniser
   // ****************************************
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         // The first stage feeds only the second stage.
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               s1_reg <= IDLE[i];
               s2_reg <= IDLE[i];
               s3_reg <= IDLE[i];
            end else begin
               s1_reg <= pin_in[i];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
            end
         end
         // Edges compare the settled stage with its delayed copy.
         assign level[i] = s2_reg;
         assign rise[i] = s2_reg & ~s3_reg;
         assign fall[i] = ~s2_reg & s3_reg;
      end
   endgenerate
endmodule
`default_nettype wire

//--- logic/fsw_status_ctrl.sv
// Status register, write latch and busy control of a serial flash.
`timescale 1ns/1ns
`default_nettype none
`include "fsw_cfg.svh"
module fsw_status_ctrl import fsw_pkg::*; (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic sck_pin,
   input wire logic cs_n_pin,
   input wire logic si_pin,
   input wire logic wp_n_pin,
   input wire logic hold_n_pin,
   input wire logic [7:0] ext_reg_value,
   input wire logic op_done,
   output logic so_out,
   output logic so_oe,
   output logic [7:0] status_value,
   output logic quad_pins_data,
   output logic cmd_pulse,
   output logic [7:0] cmd_code,
   output logic op_start,
   output logic suspend_pulse,
   output logic resume_pulse,
   output logic abort_pulse
);
   // ****************************************
   // Pin synchronisation
   // ****************************************
   logic [4:0] pin_lvl;
   logic [4:0] pin_rise;
   logic [4:0] pin_fall;
   logic sck_rise;
   logic sck_fall;
   logic cs_lvl;
   logic frame_end;
   logic si_lvl;
   logic wp_lvl;
   logic hold_lvl;

   // Every pin passes two flip-flops before use.
   fsw_pin_sync #(
      .W(5),
      .IDLE(`FSW_PIN_IDLE)
   ) u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .pin_in({hold_n_pin, wp_n_pin, si_pin, cs_n_pin, sck_pin}),
      .level(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // Named views of the synchronised pins.
   assign sck_rise = pin_rise[0];
   assign sck_fall = pin_fall[0];
   assign cs_lvl = pin_lvl[1];
   assign frame_end = pin_rise[1];
   assign si_lvl = pin_lvl[2];
   assign wp_lvl = pin_lvl[3];
   assign hold_lvl = pin_lvl[4];

   // ****************************************
   // State declarations
   // ****************************************
   logic [4:0] bit_cnt_reg;
   logic [7:0] in_shift_reg;
   logic [7:0] cmd_reg;
   logic [7:0] data_reg;
   logic got_op_reg;
   logic got_data_reg;
   logic read_act_reg;
   logic read_ext_reg;
   logic [7:0] out_shift_reg;
   logic [2:0] out_cnt_reg;
   logic [5:0] nv_bits_reg;
   logic wel_reg;
   logic rst_arm_reg;
   logic op_pe_reg;
   fsw_state_e state_reg;
   fsw_cls_e cls;
   logic [7:0] in_now;
   logic opc_strobe;
   logic dat_strobe;
   logic busy_flag;
   logic [7:0] status_now;
   logic qe;
   logic status_write_disable;
   logic [3:0] bp;
   logic is_chip;
   logic sr_ok;
   logic cer_ok;
   logic cmd_seen;
   logic start_op;
   logic vol_now;
   logic write_enable_cmd_now;
   logic write_disable_cmd_now;
   logic suspend_now;
   logic resume_now;
   logic reset_now;

   // ****************************************
   // Instruction classes
   // ****************************************
   // Sorts an opcode by whether it needs the latch and sets busy.
   function automatic fsw_cls_e op_class(input logic [7:0] op);
      case (op)
         `FSW_C_PROG_A, `FSW_C_PROG_B, `FSW_C_PROG_C, `FSW_C_PROG_D,
         `FSW_C_PROG_E, `FSW_C_PROG_F, `FSW_C_ERS_A, `FSW_C_ERS_B,
         `FSW_C_ERS_C, `FSW_C_ERS_D, `FSW_C_ERS_E, `FSW_C_ERS_F,
         `FSW_C_ERS_G, `FSW_C_CHIP_A, `FSW_C_CHIP_B: begin // RL17 RL18
            op_class = fsw_cls_pe;
         end
         `FSW_C_WR_SR, `FSW_C_FUNC, `FSW_C_RP_NV, `FSW_C_XRP_NV,
         `FSW_C_BANK_NV, `FSW_C_IROW_E, `FSW_C_IROW_P, `FSW_C_PLK_A,
         `FSW_C_PLK_B, `FSW_C_PLK_E, `FSW_C_PMODE, `FSW_C_PLKBIT,
         `FSW_C_FREEZE, `FSW_C_GANG_L, `FSW_C_GANG_U, `FSW_C_PWD,
         `FSW_C_LRN_NV, `FSW_C_ECC: begin // RL19 RL20 RL21
            op_class = fsw_cls_nv;
         end
         `FSW_C_RP_V, `FSW_C_XRP_V, `FSW_C_BANK_V, `FSW_C_DLK_A,
         `FSW_C_DLK_B, `FSW_C_LRN_V: begin
            op_class = fsw_cls_vol;
         end
         `FSW_C_RP_V2, `FSW_C_BANK_V2: begin
            op_class = fsw_cls_free; // RL22
         end
         default: begin
            op_class = fsw_cls_none;
         end
      endcase
   endfunction

   // ****************************************
   // Status composition
   // ****************************************
   // Fields of the status byte and the pin role.
   assign busy_flag = (state_reg == fsw_busy); // RL2
   assign bp = nv_bits_reg[3:0]; // RL4
   assign qe = nv_bits_reg[`FSW_B_QE - `FSW_B_BP]; // RL5
   assign status_write_disable = nv_bits_reg[`FSW_B_STATUS_WRITE_DISABLE - `FSW_B_BP]; // RL6
   assign status_now = {nv_bits_reg, wel_reg, busy_flag}; // RL2 RL3
   assign quad_pins_data = qe; // RL24

   // Registered copy of the status byte for the core.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         status_value <= `FSW_SR_RST;
      end else begin
         status_value <= status_now;
      end
   end

   // ****************************************
   // Serial input
   // ****************************************
   // Byte boundaries of the incoming frame.
   assign in_now = {in_shift_reg[6:0], si_lvl};
   assign opc_strobe = sck_rise & ~cs_lvl & (bit_cnt_reg == `FSW_OP_LAST);
   assign dat_strobe = sck_rise & ~cs_lvl & (bit_cnt_reg == `FSW_DAT_LAST);

   // Shifts data in on the rising clock edge.
   always_ff @(posedge core_clk) begin
      if (sys_rst || cs_lvl) begin
         bit_cnt_reg <= '0;
         in_shift_reg <= '0;
      end else if (sck_rise) begin
         in_shift_reg <= in_now;
         if (bit_cnt_reg != `FSW_CNT_SAT) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
         end
      end
   end

   // Holds the opcode and first data byte of the frame.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cmd_reg <= '0;
         data_reg <= '0;
         got_op_reg <= 1'b0;
         got_data_reg <= 1'b0;
      end else begin
         if (opc_strobe) begin
            cmd_reg <= in_now;
            got_op_reg <= 1'b1;
         end else if (frame_end) begin
            got_op_reg <= 1'b0;
         end
         if (dat_strobe) begin
            data_reg <= in_now;
            got_data_reg <= 1'b1;
         end else if (frame_end) begin
            got_data_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // Register readout
   // ****************************************
   // Streams status or extended contents until the frame ends.
   always_ff @(posedge core_clk) begin
      if (sys_rst || cs_lvl) begin
         read_act_reg <= 1'b0;
         read_ext_reg <= 1'b0;
         out_cnt_reg <= '0;
         out_shift_reg <= '0;
      end else if (opc_strobe) begin
         read_act_reg <= (in_now == `FSW_C_RD_SR) || (in_now == `FSW_C_RD_EXT);
         read_ext_reg <= (in_now == `FSW_C_RD_EXT);
         out_cnt_reg <= `FSW_OUT_LAST;
         out_shift_reg <= (in_now == `FSW_C_RD_EXT) ? ext_reg_value : status_now;
      end else if (sck_fall && read_act_reg) begin
         if (out_cnt_reg == `FSW_OUT_LAST) begin
            out_shift_reg <= read_ext_reg ? ext_reg_value : status_now; // RL1
            out_cnt_reg <= '0;
         end else begin
            out_shift_reg <= {out_shift_reg[6:0], 1'b0};
            out_cnt_reg <= out_cnt_reg + 3'h1;
         end
      end
   end

   // The output pin is driven only during a register read.
   assign so_out = out_shift_reg[7];
   assign so_oe = read_act_reg;

   // ****************************************
   // Instruction decision at frame end
   // ****************************************
   // Gates that decide whether the finished frame takes effect.
   assign cls = op_class(cmd_reg);
   assign cmd_seen = frame_end & got_op_reg;
   assign is_chip = (cmd_reg == `FSW_C_CHIP_A) || (cmd_reg == `FSW_C_CHIP_B);
   assign sr_ok = !(cmd_reg == `FSW_C_WR_SR && status_write_disable && !wp_lvl && !qe); // RL23 RL24
   assign cer_ok = !(is_chip && bp != 4'h0); // RL25
   assign reset_now = (cmd_seen && cmd_reg == `FSW_C_RST && rst_arm_reg) ||
      (!qe && !hold_lvl); // RL24
   assign start_op = cmd_seen && state_reg == fsw_idle && wel_reg && // RL13
      (cls == fsw_cls_pe || cls == fsw_cls_nv) && sr_ok && cer_ok &&
      (cmd_reg != `FSW_C_WR_SR || got_data_reg) && !reset_now;
   assign vol_now = cmd_seen && state_reg != fsw_busy && !reset_now && // RL10
      ((cls == fsw_cls_vol && wel_reg) || cls == fsw_cls_free); // RL13 RL22
   assign write_enable_cmd_now = cmd_seen && state_reg != fsw_busy && cmd_reg == `FSW_C_WR_EN;
   assign write_disable_cmd_now = cmd_seen && state_reg != fsw_busy && cmd_reg == `FSW_C_WR_DIS;
   assign suspend_now = cmd_seen && state_reg == fsw_busy && op_pe_reg && // RL11
      cmd_reg == `FSW_C_SUSP && !reset_now;
   assign resume_now = cmd_seen && state_reg == fsw_susp &&
      cmd_reg == `FSW_C_RESUME && !reset_now;

   // Arms the software reset; any other instruction disarms it.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rst_arm_reg <= 1'b0;
      end else if (cmd_seen) begin
         rst_arm_reg <= (cmd_reg == `FSW_C_RST_EN);
      end
   end

   // ****************************************
   // Write cycle state machine
   // ****************************************
   // Busy runs from start until the array reports done.
   always_ff @(posedge core_clk) begin
      if (sys_rst || reset_now) begin
         state_reg <= fsw_idle;
         op_pe_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            fsw_idle: begin
               if (start_op) begin
                  state_reg <= fsw_busy; // RL9
                  op_pe_reg <= (cls == fsw_cls_pe);
               end
            end
            fsw_busy: begin
               if (op_done) begin
                  state_reg <= fsw_idle; // RL12
               end else if (suspend_now) begin
                  state_reg <= fsw_susp; // RL11
               end
            end
            fsw_susp: begin
               if (resume_now) begin
                  state_reg <= fsw_busy;
               end
            end
            default: begin
               state_reg <= fsw_idle;
            end
         endcase
      end
   end

   // ****************************************
   // Write latch and protection bits
   // ****************************************
   // Only enable sets the latch; disable and completion clear it.
   always_ff @(posedge core_clk) begin
      if (sys_rst || reset_now) begin
         wel_reg <= 1'b0;
      end else if (write_enable_cmd_now) begin
         wel_reg <= 1'b1; // RL14 RL7
      end else if (write_disable_cmd_now) begin
         wel_reg <= 1'b0; // RL15 RL7
      end else if (state_reg == fsw_busy && op_done) begin
         wel_reg <= 1'b0; // RL16
      end
   end

   // Status write loads bits 7 to 2; the latch bit is not touched.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         nv_bits_reg <= 6'(`FSW_SR_RST >> `FSW_B_BP);
      end else if (start_op && cmd_reg == `FSW_C_WR_SR) begin
         nv_bits_reg <= data_reg[7:`FSW_B_BP]; // RL8
      end
   end

   // ****************************************
   // Event outputs
   // ****************************************
   // Pulses toward the array engine, one cycle each except abort, which stays high while hold is low and quad enable is clear.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cmd_pulse <= 1'b0;
         cmd_code <= '0;
         op_start <= 1'b0;
         suspend_pulse <= 1'b0;
         resume_pulse <= 1'b0;
         abort_pulse <= 1'b0;
      end else begin
         cmd_pulse <= start_op | vol_now;
         if (start_op || vol_now) begin
            cmd_code <= cmd_reg;
         end
         op_start <= start_op;
         suspend_pulse <= suspend_now;
         resume_pulse <= resume_now;
         abort_pulse <= reset_now;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_write_enable_cmd;
      cmd_seen && state_reg != fsw_busy && cmd_reg == `FSW_C_WR_EN && !reset_now;
   endsequence
   sequence s_sr_write;
      start_op && cmd_reg == `FSW_C_WR_SR;
   endsequence
   sequence s_suspend;
      suspend_now && !op_done;
   endsequence

   property p_wel_set;
      s_write_enable_cmd |=> wel_reg;
   endproperty
   a_wel_set: assert property (p_wel_set) else $error("latch not set"); // RL14

   property p_wel_clr;
      write_disable_cmd_now && !reset_now |=> !wel_reg;
   endproperty
   a_wel_clr: assert property (p_wel_clr) else $error("latch not cleared"); // RL15

   property p_sr_write;
      s_sr_write |=> nv_bits_reg == $past(data_reg[7:2]) && wel_reg == $past(wel_reg)
         ##1 busy_flag || $past(op_done);
   endproperty
   a_sr_write: assert property (p_sr_write) else $error("status write wrong"); // RL8 RL7

   property p_done;
      busy_flag && op_done && !reset_now |=> !busy_flag && !wel_reg;
   endproperty
   a_done: assert property (p_done) else $error("done did not clear"); // RL12 RL16

   property p_deaf;
      cmd_seen && busy_flag && !op_done && !reset_now |=> $stable(wel_reg) && !op_start
         && !cmd_pulse;
   endproperty
   a_deaf: assert property (p_deaf) else $error("busy took command"); // RL10

   property p_refuse;
      cmd_seen && !wel_reg && (cls == fsw_cls_pe || cls == fsw_cls_nv) |=> !op_start;
   endproperty
   a_refuse: assert property (p_refuse) else $error("unguarded start"); // RL13

   property p_chip;
      cmd_seen && is_chip && bp != 4'h0 |=> !op_start ##1 !busy_flag || $past(state_reg) != fsw_idle;
   endproperty
   a_chip: assert property (p_chip) else $error("protected chip erase"); // RL25

   property p_lock;
      cmd_seen && !sr_ok |=> $stable(nv_bits_reg);
   endproperty
   a_lock: assert property (p_lock) else $error("locked status changed"); // RL23

   property p_free;
      cmd_seen && state_reg == fsw_idle && cls == fsw_cls_free && !reset_now
         |=> cmd_pulse && cmd_code == $past(cmd_reg);
   endproperty
   a_free: assert property (p_free) else $error("free command lost"); // RL22

   property p_start;
      start_op |=> op_start && busy_flag && status_value[`FSW_B_BUSY] == 1'b0 ##1
         status_value[`FSW_B_BUSY] || !busy_flag;
   endproperty
   a_start: assert property (p_start) else $error("busy not raised"); // RL9 RL2

   property p_suspend;
      s_suspend |=> suspend_pulse && !busy_flag;
   endproperty
   a_suspend: assert property (p_suspend) else $error("suspend refused"); // RL11

   property p_repeat;
      read_act_reg && sck_fall && out_cnt_reg == `FSW_OUT_LAST && !cs_lvl && !read_ext_reg
         |=> so_out == $past(status_now[7]);
   endproperty
   a_repeat: assert property (p_repeat) else $error("status not repeated"); // RL1
endmodule
`default_nettype wire

//--- verif/fsw_host_model.sv
// Host serial controller model that drives frames into the flash status block.
`timescale 1ns/1ns
`default_nettype none
module fsw_host_model (
   output logic sck_pin,
   output logic cs_n_pin,
   output logic si_pin,
   input wire logic so_out,
   input wire logic so_oe
);
   // Clock rests low and select rests high outside frames.
   initial begin
      sck_pin = 1'b0;
      cs_n_pin = 1'b1;
      si_pin = 1'b0;
   end
   // Shifts nb bits out MSB first, then clocks rb more and samples the reply in each high phase.
   task automatic frame(input logic [15:0] w, input int nb, input int rb,
      output logic [15:0] rd);
      rd = '0;
      #13;
      cs_n_pin = 1'b0;
      for (int i = 0; i < nb + rb; i++) begin
         si_pin = (i < nb) ? w[15 - i] : ~si_pin;
         #200;
         sck_pin = 1'b1;
         #100;
         if (i >= nb) begin
            rd = {rd[14:0], so_oe ? so_out : 1'bx};
         end
         #100;
         sck_pin = 1'b0;
      end
      #200;
      cs_n_pin = 1'b1;
      si_pin = ~si_pin; // A released data line must not keep its last value.
      #200;
   endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the flash status register and write latch block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic wp_n_pin = 1'b1;
   logic hold_n_pin = 1'b1;
   logic [7:0] ext_reg_value = 8'h00;
   logic op_done = 1'b0;
   wire sck_pin;
   wire cs_n_pin;
   wire si_pin;
   logic so_out, so_oe, quad_pins_data, cmd_pulse, op_start, suspend_pulse;
   logic resume_pulse, abort_pulse;
   logic [7:0] status_value, cmd_code;
   logic [15:0] rd;
   logic [7:0] rnd;
   logic [5:0] m_nv = 6'h00;
   logic m_busy = 1'b0, m_wel = 1'b0, m_susp = 1'b0, m_arm = 1'b0, m_pe = 1'b0;
   int err_count = 0, checked = 0, n_start = 0, n_cmd = 0, n_susp = 0;
   int x_start = 0, x_cmd = 0, x_susp = 0;
   int n_res = 0, n_abt = 0, x_res = 0, x_abt = 0;
   logic [7:0] pe_q[$] = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e, 8'hd7, 8'h20, 8'h21,
      8'h52, 8'h5c, 8'hd8, 8'hdc, 8'hc7, 8'h60};
   logic [7:0] nv_q[$] = '{8'h01, 8'h42, 8'h65, 8'h85, 8'h18, 8'h64, 8'h62, 8'hfd, 8'he3,
      8'he4, 8'h2f, 8'ha6, 8'h91, 8'h7e, 8'h98, 8'he8, 8'h43, 8'hb5};
   logic [7:0] vol_q[$] = '{8'h63, 8'h83, 8'hc5, 8'hfb, 8'he1, 8'h4a};

   fsw_host_model i_host (.sck_pin(sck_pin), .cs_n_pin(cs_n_pin), .si_pin(si_pin),
      .so_out(so_out), .so_oe(so_oe));
   fsw_status_ctrl i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .sck_pin(sck_pin),
      .cs_n_pin(cs_n_pin), .si_pin(si_pin), .wp_n_pin(wp_n_pin), .hold_n_pin(hold_n_pin),
      .ext_reg_value(ext_reg_value), .op_done(op_done), .so_out(so_out), .so_oe(so_oe),
      .status_value(status_value), .quad_pins_data(quad_pins_data), .cmd_pulse(cmd_pulse),
      .cmd_code(cmd_code), .op_start(op_start), .suspend_pulse(suspend_pulse),
      .resume_pulse(resume_pulse), .abort_pulse(abort_pulse));

   // Core clock of 50 ns period.
   always #25 core_clk = ~core_clk;
   // Counts the one-cycle pulses so that none slips by between checks.
   always @(posedge core_clk) begin
      if (op_start === 1'b1) n_start++;
      if (cmd_pulse === 1'b1) n_cmd++;
      if (suspend_pulse === 1'b1) n_susp++;
      if (resume_pulse === 1'b1) n_res++;
      if (abort_pulse === 1'b1) n_abt++;
   end

   function automatic logic [7:0] exp_sr();
      return {m_nv, m_wel, m_busy};
   endfunction

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_all();
      repeat (8) @(posedge core_clk);
      cmp({8'h00, status_value}, {8'h00, exp_sr()});
      cmp(16'(n_start), 16'(x_start));
      cmp(16'(n_cmd), 16'(x_cmd));
      cmp(16'(n_susp), 16'(x_susp));
      cmp(16'(n_res), 16'(x_res));
      cmp(16'(n_abt), 16'(x_abt));
      cmp({15'h0, quad_pins_data}, {15'h0, m_nv[4]});
   endtask

   // Sends one instruction frame and updates the reference model from the rules.
   task automatic send(input logic [7:0] op, input logic [7:0] dat, input int nb);
      int k;
      logic arm;
      k = 0;
      arm = m_arm;
      i_host.frame({op, dat}, nb, 0, rd);
      foreach (pe_q[i]) if (pe_q[i] == op) k = 1;
      foreach (nv_q[i]) if (nv_q[i] == op) k = 2;
      foreach (vol_q[i]) if (vol_q[i] == op) k = 3;
      m_arm = (op == 8'h66);
      if (k == 1 || k == 2) begin
         if (m_wel && !m_busy && !m_susp && !((op == 8'hc7 || op == 8'h60) && m_nv[3:0] != 0)
            && !(op == 8'h01 && (nb < 16 || (m_nv[5] && !wp_n_pin && !m_nv[4])))) begin
            m_busy = 1'b1;
            m_pe = (k == 1);
            x_start++;
            x_cmd++;
            if (op == 8'h01) m_nv = dat[7:2];
         end
      end else if (k == 3) begin
         if (!m_busy && m_wel) x_cmd++;
      end else begin
         case (op)
            8'h06: if (!m_busy) m_wel = 1'b1;
            8'h04: if (!m_busy) m_wel = 1'b0;
            8'hc0, 8'h17: if (!m_busy) x_cmd++;
            8'h75: if (m_busy && m_pe) begin
               m_busy = 1'b0;
               m_susp = 1'b1;
               x_susp++;
            end
            8'h7a: if (m_susp) begin
               m_busy = 1'b1;
               m_susp = 1'b0;
               x_res++;
            end
            8'h99: if (arm) begin
               {m_busy, m_wel, m_susp} = 3'b000;
               x_abt++;
            end
            default: ;
         endcase
      end
      check_all();
   endtask

   task automatic rd_reg(input logic [7:0] op, input logic [7:0] exp);
      i_host.frame({op, 8'h00}, 8, 16, rd);
      cmp(rd, {exp, exp});
   endtask

   task automatic finish_op();
      @(posedge core_clk) op_done <= 1'b1;
      @(posedge core_clk) op_done <= 1'b0;
      if (m_busy) {m_busy, m_wel} = 2'b00;
      check_all();
   endtask

   task automatic complete_run();
      $display("Mismatches %0d of %0d comparisons", err_count, checked);
      if (err_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Cuts a hang short well beyond the expected run of about 1 ms.
   initial begin
      #3000000;
      err_count++;
      complete_run();
   end

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      rnd = 8'($urandom(32'he74dacf4));
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      check_all();
      rd_reg(8'h05, exp_sr());
      foreach (pe_q[i]) begin
         send(pe_q[i], 8'h00, 16);
         send(8'h06, 8'h00, 8);
         send(pe_q[i], 8'h00, 16);
         send(8'h06, 8'h00, 8);
         rd_reg(8'h05, exp_sr());
         finish_op();
      end
      foreach (nv_q[i]) begin
         send(8'h06, 8'h00, 8);
         send(nv_q[i], 8'h00, 16);
         cmp({8'h00, cmd_code}, {8'h00, nv_q[i]});
         finish_op();
      end
      foreach (vol_q[i]) begin
         send(vol_q[i], 8'h00, 16);
         send(8'h06, 8'h00, 8);
         send(vol_q[i], 8'h00, 16);
         send(8'h04, 8'h00, 8);
      end
      send(8'hc0, 8'h00, 16);
      send(8'h17, 8'h00, 16);
      send(8'h06, 8'h00, 8);
      send(8'h01, 8'h00, 8);
      rnd = (8'($urandom) & 8'h38) | 8'h84;
      send(8'h01, rnd, 16);
      finish_op();
      send(8'h06, 8'h00, 8);
      send(8'hc7, 8'h00, 16);
      @(posedge core_clk) wp_n_pin <= 1'b0;
      send(8'h01, 8'h00, 16);
      @(posedge core_clk) wp_n_pin <= 1'b1;
      send(8'h01, 8'h40, 16);
      finish_op();
      send(8'h06, 8'h00, 8);
      send(8'h01, 8'h00, 16);
      finish_op();
      send(8'h06, 8'h00, 8);
      send(8'h02, 8'h00, 16);
      send(8'h75, 8'h00, 8);
      rd_reg(8'h05, exp_sr());
      send(8'h7a, 8'h00, 8);
      finish_op();
      send(8'h06, 8'h00, 8);
      send(8'h01, 8'h00, 16);
      send(8'h75, 8'h00, 8);
      rnd = 8'($urandom);
      @(posedge core_clk) ext_reg_value <= rnd;
      rd_reg(8'h81, rnd);
      @(posedge core_clk) hold_n_pin <= 1'b0;
      repeat (6) @(posedge core_clk);
      hold_n_pin <= 1'b1;
      {m_busy, m_wel, m_susp} = 3'b000;
      x_abt += 6;
      check_all();
      send(8'h06, 8'h00, 8);
      send(8'h02, 8'h00, 16);
      send(8'h66, 8'h00, 8);
      send(8'h99, 8'h00, 8);
      complete_run();
   end
endmodule
`default_nettype wire
